//--- include/mbr_defines.vh
// Purpose: Constants for the ASCII register-read framer.
// Assumes: Included by bare name from rtl files.
// Notes: Definitions only.
`ifndef MBR_DEFINES_VH
`define MBR_DEFINES_VH

// ==========================================
// Frame characters
`define MBR_CH_COLON 8'h3A
`define MBR_CH_CR 8'h0D
`define MBR_CH_LF 8'h0A
`define MBR_CH_0 8'h30
`define MBR_CH_9 8'h39
`define MBR_CH_A 8'h41
`define MBR_CH_F 8'h46
`define MBR_CH_A_OFS 8'h37

// ==========================================
// Function and query layout
`define MBR_FUNC_READ 8'h03
`define MBR_BROADCAST 8'h00
`define MBR_QUERY_BYTES 4'h7
`define MBR_MAX_REGS 8'h7B

// ==========================================
// Byte slots of a query
`define MBR_SLOT_ADDR 4'h0
`define MBR_SLOT_FUNC 4'h1
`define MBR_SLOT_STHI 4'h2
`define MBR_SLOT_STLO 4'h3
`define MBR_SLOT_CNHI 4'h4
`define MBR_SLOT_CNLO 4'h5

// ==========================================
// Response byte selectors
`define MBR_SEL_ADDR 3'h0
`define MBR_SEL_FUNC 3'h1
`define MBR_SEL_CNT 3'h2
`define MBR_SEL_DATA 3'h3
`define MBR_SEL_LRC 3'h4

`endif

//--- rtl/mbr_read_framer.v
// Purpose: Slave framer for ASCII function 03 register reads.
// Assumes: Character stream comes from same-clock serial logic.
// Notes: Register source answers in the same cycle that regRd is high.
`timescale 1ns/1ps
`include "mbr_defines.vh"

module mbr_read_framer #(
	parameter MAX_REGS = 8'h7B
)(
	// Clock and reset
	input wire clock,
	input wire sys_rst,
	input wire clkEn,
	// Own station address
	input wire [7:0] slaveAddr,
	// Receive character stream
	input wire [7:0] rxChar,
	input wire rxValid,
	output wire rxReady,
	// Transmit character stream
	output reg [7:0] txChar,
	output reg txValid,
	input wire txReady,
	// Register source
	output reg [15:0] regAddr,
	output reg regRd,
	input wire [15:0] regData
);

// ==========================================
// States
localparam ST_RX = 5'h01;
localparam ST_HEAD = 5'h02;
localparam ST_HEX = 5'h04;
localparam ST_FETCH = 5'h08;
localparam ST_TAIL = 5'h10;

// ==========================================
// Helpers
function isHex;
	input [7:0] c;
	begin
		isHex = ((c >= `MBR_CH_0) && (c <= `MBR_CH_9)) ||
			((c >= `MBR_CH_A) && (c <= `MBR_CH_F));
	end
endfunction

function [3:0] hexVal;
	input [7:0] c;
	begin
		hexVal = (c <= `MBR_CH_9) ? c[3:0] : c[3:0] + 4'h9;
	end
endfunction
function [7:0] toHex;
	input [3:0] n;
	begin
		toHex = (n <= 4'h9) ? `MBR_CH_0 + {4'h0, n} : `MBR_CH_A_OFS + {4'h0, n};
	end
endfunction

// ==========================================
// State
reg [4:0] state_reg;
reg inFrame_reg;
reg gotCr_reg;
reg rxPhase_reg;
reg [3:0] hiNib_reg;
reg [3:0] rxCount_reg;
reg [7:0] rxSum_reg;
reg [7:0] qAddr_reg;
reg [7:0] qFunc_reg;
reg [15:0] qStart_reg;
reg [15:0] qCount_reg;
reg [7:0] txByte_reg;
reg txLow_reg;
reg [2:0] byteSel_reg;
reg [7:0] txSum_reg;
reg [7:0] regLeft_reg;
reg [7:0] dataLo_reg;
reg dataLow_reg;
reg fetchWait_reg;
reg tailLf_reg;

wire [3:0] rxNib = hexVal(rxChar);
wire [7:0] rxByte = {hiNib_reg, rxNib};
wire [7:0] rxSumNext = rxSum_reg + rxByte;
wire slotFree = !txValid || txReady;
wire [7:0] txSumNext = txSum_reg + txByte_reg;
wire queryOk = (rxCount_reg == `MBR_QUERY_BYTES) && !rxPhase_reg
	&& (rxSum_reg == 8'h00)
	&& (qAddr_reg == slaveAddr) && (qAddr_reg != `MBR_BROADCAST)
	&& (qFunc_reg == `MBR_FUNC_READ)
	&& (qCount_reg != 16'h0000) && (qCount_reg <= {8'h00, MAX_REGS});
assign rxReady = (state_reg == ST_RX);
// ==========================================
// Main sequencer
always @(posedge clock)
begin
	if (sys_rst)
	begin
		state_reg <= ST_RX;
		inFrame_reg <= 1'b0;
		gotCr_reg <= 1'b0;
		rxPhase_reg <= 1'b0;
		hiNib_reg <= 4'h0;
		rxCount_reg <= 4'h0;
		rxSum_reg <= 8'h00;
		qAddr_reg <= 8'h00;
		qFunc_reg <= 8'h00;
		qStart_reg <= 16'h0000;
		qCount_reg <= 16'h0000;
		txByte_reg <= 8'h00;
		txLow_reg <= 1'b0;
		byteSel_reg <= `MBR_SEL_ADDR;
		txSum_reg <= 8'h00;
		regLeft_reg <= 8'h00;
		dataLo_reg <= 8'h00;
		dataLow_reg <= 1'b0;
		fetchWait_reg <= 1'b0;
		tailLf_reg <= 1'b0;
		txChar <= 8'h00;
		txValid <= 1'b0;
		regAddr <= 16'h0000;
		regRd <= 1'b0;
	end
	else if (clkEn)
	begin
		regRd <= 1'b0;
		txValid <= txValid && !txReady;
		case (state_reg)
		ST_RX:
		begin
			if (rxValid)
			begin
				if (rxChar == `MBR_CH_COLON)
				begin
					inFrame_reg <= 1'b1;
					gotCr_reg <= 1'b0;
					rxPhase_reg <= 1'b0;
					rxCount_reg <= 4'h0;
					rxSum_reg <= 8'h00;
				end
				else if (inFrame_reg && !gotCr_reg && isHex(rxChar))
				begin
					if (!rxPhase_reg)
					begin
						hiNib_reg <= rxNib;
						rxPhase_reg <= 1'b1;
					end
					else
					begin
						// bytes land in their query slots
						rxPhase_reg <= 1'b0;
						rxSum_reg <= rxSumNext;
						rxCount_reg <= rxCount_reg + 4'h1;
						case (rxCount_reg)
						`MBR_SLOT_ADDR: qAddr_reg <= rxByte;
						`MBR_SLOT_FUNC: qFunc_reg <= rxByte;
						`MBR_SLOT_STHI: qStart_reg[15:8] <= rxByte;
						`MBR_SLOT_STLO: qStart_reg[7:0] <= rxByte;
						`MBR_SLOT_CNHI: qCount_reg[15:8] <= rxByte;
						`MBR_SLOT_CNLO: qCount_reg[7:0] <= rxByte;
						default: ;
						endcase
						// Overlong frame cannot be a read query
						if (rxCount_reg == `MBR_QUERY_BYTES)
							inFrame_reg <= 1'b0;
					end
				end
				else if (inFrame_reg && !gotCr_reg && rxChar == `MBR_CH_CR)
					gotCr_reg <= 1'b1;
				else if (inFrame_reg && gotCr_reg && rxChar == `MBR_CH_LF)
				begin
					inFrame_reg <= 1'b0;
					if (queryOk)
					begin
						state_reg <= ST_HEAD;
						regAddr <= qStart_reg;
						regLeft_reg <= qCount_reg[7:0];
					end
				end
				else
					inFrame_reg <= 1'b0;
			end
		end
		ST_HEAD:
		begin
			if (slotFree)
			begin
				txChar <= `MBR_CH_COLON;
				txValid <= 1'b1;
				txByte_reg <= qAddr_reg;
				byteSel_reg <= `MBR_SEL_ADDR;
				txLow_reg <= 1'b0;
				txSum_reg <= 8'h00;
				state_reg <= ST_HEX;
			end
		end
		ST_HEX:
		begin
			if (slotFree)
			begin
				txValid <= 1'b1;
				txChar <= toHex(txLow_reg ? txByte_reg[3:0] : txByte_reg[7:4]);
				txLow_reg <= !txLow_reg;
				if (txLow_reg)
				begin
					txSum_reg <= txSumNext;
					case (byteSel_reg)
					`MBR_SEL_ADDR:
					begin
						txByte_reg <= `MBR_FUNC_READ;
						byteSel_reg <= `MBR_SEL_FUNC;
					end
					`MBR_SEL_FUNC:
					begin
						txByte_reg <= {qCount_reg[6:0], 1'b0};
						byteSel_reg <= `MBR_SEL_CNT;
					end
					`MBR_SEL_CNT:
					begin
						byteSel_reg <= `MBR_SEL_DATA;
						state_reg <= ST_FETCH;
					end
					`MBR_SEL_DATA:
					begin
						if (!dataLow_reg)
						begin
							txByte_reg <= dataLo_reg;
							dataLow_reg <= 1'b1;
						end
						else if (regLeft_reg != 8'h00)
							state_reg <= ST_FETCH;
						else
						begin
							txByte_reg <= 8'h00 - txSumNext;
							byteSel_reg <= `MBR_SEL_LRC;
						end
					end
					default:
					begin
						tailLf_reg <= 1'b0;
						state_reg <= ST_TAIL;
					end
					endcase
				end
			end
		end
		ST_FETCH:
		begin
			// Data taken in the same cycle the read strobe is high
			if (!fetchWait_reg)
			begin
				regRd <= 1'b1;
				fetchWait_reg <= 1'b1;
			end
			else
			begin
				fetchWait_reg <= 1'b0;
				txByte_reg <= regData[15:8];
				dataLo_reg <= regData[7:0];
				dataLow_reg <= 1'b0;
				regAddr <= regAddr + 16'h0001;
				regLeft_reg <= regLeft_reg - 8'h01;
				state_reg <= ST_HEX;
			end
		end
		ST_TAIL:
		begin
			if (slotFree)
			begin
				txValid <= 1'b1;
				txChar <= tailLf_reg ? `MBR_CH_LF : `MBR_CH_CR;
				tailLf_reg <= 1'b1;
				if (tailLf_reg)
					state_reg <= ST_RX;
			end
		end
		default:
			state_reg <= ST_RX;
		endcase
	end
end
endmodule // mbr_read_framer

//--- tb/mbr_read_framer_asserts.sv
// Purpose: Port-level checks for the register-read framer.
// Assumes: clkEn is held high by the bench.
// Notes: Bound into every framer instance.
`timescale 1ns/1ps
module mbr_read_framer_asserts #(
	parameter MAX_REGS = 8'h7B
)(
	// Clock and reset
	input logic clock,
	input logic sys_rst,
	input logic clkEn,
	// Character streams
	input logic [7:0] slaveAddr,
	input logic [7:0] rxChar,
	input logic rxValid,
	input logic rxReady,
	input logic [7:0] txChar,
	input logic txValid,
	input logic txReady,
	// Register source
	input logic [15:0] regAddr,
	input logic regRd,
	input logic [15:0] regData
);
	logic [15:0] lastAddr_reg;
	logic readSeen_reg;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// Fetch tracking, cleared once listening again
	always_ff @(posedge clock)
	begin
		if (sys_rst || rxReady)
			readSeen_reg <= 1'b0;
		else if (regRd)
			readSeen_reg <= 1'b1;
		if (regRd)
			lastAddr_reg <= regAddr;
	end
	rd_pulse_a: assert property (regRd |=> !regRd) else $error("long read");
	addr_step_a: assert property (regRd && readSeen_reg |-> regAddr == lastAddr_reg + 16'h0001)
		else $error("fetch not ascending");
	rd_busy_a: assert property (regRd |-> !rxReady) else $error("read while idle");
	tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txChar))
		else $error("char dropped");
	colon_lead_a: assert property ($fell(rxReady) |-> ##[0:4] txValid && txChar == 8'h3A)
		else $error("no header");
	lf_release_a: assert property ($rose(rxReady) |-> txChar == 8'h0A || $past(txChar) == 8'h0A)
		else $error("early release");
	cr_lf_a: assert property (txValid && txChar == 8'h0A && $past(txChar) != 8'h0A
		|-> $past(txChar) == 8'h0D) else $error("LF without CR");
	hex_char_a: assert property (txValid |-> txChar inside {8'h3A, 8'h0D, 8'h0A,
		[8'h30:8'h39], [8'h41:8'h46]}) else $error("bad char");
	cover property (regRd);
	cover property (txValid && !txReady);
	cover property ($rose(rxReady));
endmodule // mbr_read_framer_asserts

bind mbr_read_framer mbr_read_framer_asserts #(.MAX_REGS(MAX_REGS)) u_chk (.clock(clock),
	.sys_rst(sys_rst), .clkEn(clkEn), .slaveAddr(slaveAddr), .rxChar(rxChar),
	.rxValid(rxValid), .rxReady(rxReady), .txChar(txChar), .txValid(txValid),
	.txReady(txReady), .regAddr(regAddr), .regRd(regRd), .regData(regData));

//--- tb/mbr_host_model.sv
// Purpose: Host master model sending read queries.
// Assumes: Same clock as the framer.
// Notes: Line shows inverted data between frames.
`timescale 1ns/1ps
module mbr_host_model (
	// Clock
	input wire clock,
	// Query stream
	output reg [7:0] rxChar,
	output reg rxValid,
	input wire rxReady,
	// Response sink
	output reg txReady
);
	integer seed = 32'h7D51;
	reg [7:0] sum;
	reg rdyN;
	initial
	begin
		rxChar = 8'hC5;
		rxValid = 1'b0;
		txReady = 1'b0;
	end
	// Random stalls, so held characters get exercised
	always @(posedge clock)
		txReady <= ($random(seed) % 4) != 0;
	// Ready sampled mid-cycle to avoid racing the edge
	always @(negedge clock)
		rdyN = rxReady;
	function [7:0] hx(input [3:0] v);
		hx = (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
	endfunction
	task putc(input [7:0] c);
	begin
		rxChar <= c;
		rxValid <= 1'b1;
		do @(posedge clock); while (!rdyN);
	end
	endtask
	task putb(input [7:0] b);
	begin
		sum = sum + b;
		putc(hx(b[7:4]));
		putc(hx(b[3:0]));
	end
	endtask
	task query(input [7:0] a, input [7:0] f, input [15:0] s, input [15:0] n, input bad);
	begin
		sum = 8'h00;
		putc(8'h3A);
		putb(a);
		putb(f);
		putb(s[15:8]);
		putb(s[7:0]);
		putb(n[15:8]);
		putb(n[7:0]);
		putb((8'h00 - sum) ^ {7'h00, bad});
		putc(8'h0D);
		putc(8'h0A);
		rxValid <= 1'b0;
		rxChar <= 8'hF5;
	end
	endtask
endmodule // mbr_host_model

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the register-read framer.
// Assumes: Register source answers combinationally while regRd is high.
// Notes: Expected characters queue up before each query.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
	$display("FAIL %0t mismatch", $time); end end
module tb_top;
	reg clock = 1'b0;
	reg sys_rst = 1'b1;
	reg clkEn = 1'b1;
	reg [7:0] slaveAddr = 8'h01;
	reg [7:0] sum;
	reg [7:0] a;
	reg [7:0] expQ[$];
	wire [7:0] rxChar, txChar;
	wire rxValid, rxReady, txValid, txReady, regRd;
	wire [15:0] regAddr, regData;
	integer err_total = 0, samples_checked = 0, seed = 32'h7D51, i, k, j;
	initial forever #20 clock = ~clock;
	assign regData = regRd ? regAddr ^ 16'hC35A : ~regAddr;
	mbr_host_model host (.clock(clock), .rxChar(rxChar), .rxValid(rxValid),
		.rxReady(rxReady), .txReady(txReady));
	mbr_read_framer u_dut (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
		.slaveAddr(slaveAddr), .rxChar(rxChar), .rxValid(rxValid), .rxReady(rxReady),
		.txChar(txChar), .txValid(txValid), .txReady(txReady), .regAddr(regAddr),
		.regRd(regRd), .regData(regData));
	// ==========================================
	// Response watcher
	always @(posedge clock)
		if (txValid && txReady)
		begin
			`CHK(expQ.size() != 0, 1'b1)
			if (expQ.size() != 0)
				`CHK(txChar, expQ.pop_front())
		end
	task pe(input [7:0] b);
	begin
		sum = sum + b;
		expQ.push_back(host.hx(b[7:4]));
		expQ.push_back(host.hx(b[3:0]));
	end
	endtask
	task ask(input [7:0] ad, input [7:0] f, input [15:0] s, input [15:0] n, input bad, ok);
		reg [15:0] d;
	begin
		if (ok)
		begin
			sum = 8'h00;
			expQ.push_back(8'h3A);
			pe(ad);
			pe(f);
			pe(n[7:0] + n[7:0]);
			for (i = 0; i < n; i++)
			begin
				d = (s + i[15:0]) ^ 16'hC35A;
				pe(d[15:8]);
				pe(d[7:0]);
			end
			pe(8'h00 - sum);
			expQ.push_back(8'h0D);
			expQ.push_back(8'h0A);
		end
		host.query(ad, f, s, n, bad);
		for (k = 0; k < 4000 && expQ.size() != 0; k++)
			@(posedge clock);
		repeat (8) @(posedge clock);
		@(negedge clock);
		`CHK(expQ.size(), 0)
		`CHK(rxReady, 1'b1)
		@(posedge clock);
	end
	endtask
	task finish_test;
	begin
		$display("Compared %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	initial
	begin
		#3000000;
		err_total++;
		finish_test;
	end
	// ==========================================
	// Scenarios
	initial
	begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		ask(8'h01, 8'h03, 16'h9000, 16'h000A, 0, 1);
		ask(8'h02, 8'h03, 16'h9000, 16'h0001, 0, 0);
		// Own address zero too, so only the broadcast guard can drop it
		slaveAddr <= 8'h00;
		ask(8'h00, 8'h03, 16'h9000, 16'h0001, 0, 0);
		slaveAddr <= 8'h01;
		ask(8'h01, 8'h03, 16'h0500, 16'h0006, 1, 0);
		ask(8'h01, 8'h04, 16'h0500, 16'h0006, 0, 0);
		ask(8'h01, 8'h03, 16'h0500, 16'h0000, 0, 0);
		slaveAddr <= 8'h10;
		ask(8'h10, 8'h03, 16'h1000, 16'h007B, 0, 1);
		ask(8'h10, 8'h03, 16'h1000, 16'h007C, 0, 0);
		for (j = 0; j < 6; j++)
		begin
			a = ($random(seed) & 8'h0F) + 8'h01;
			slaveAddr <= a;
			// Start kept low enough that the span never wraps
			ask(a, 8'h03, 16'($random(seed)) & 16'hFFF0, 16'(($random(seed) & 7) + 1), 0, 1);
		end
		finish_test;
	end
endmodule // tb_top
